// ===== core/flash_access_dev.sv
// Gauge end: command space, parameter store, info area and security states.
// Assumes the host end on the same clk_sys, one command in flight at a time.
//
// Contract
// - Separate 32-byte user information area exists.
// - Unsealed general mode reaches info like parameters.
// - Host writes subclass, then block selector.
// - Commit only after correct checksum written.
// - Sealed or mode nonzero: block selector alone.
// - Block 1 or 2 loads info window.
// - Unsealed restricted checksum writes window back to info.
// - Sealed never modifies information area.
// - Three security states gate store access.
// - Key updates only in full access.
// - Key pair back to back on control.
// - Host keys differ from subcommand codes.
// - Sealed flag clears on unseal pair.
// - Full-access flag clears on full pair.
// - Keys are two bytes, kept in store.
// - Host sends key 1 then key 0.
// - Control key bytes swapped against stored.
// - Fixed parameter locations with defaults.
// - Checksum is complement of byte sum.
// - Mode 0 general, mode 1 restricted.
// - Host uses block offset/32, window offset%32.
// - Overlong block write is ignored.
`include "flash_access_cfg.svh"
`default_nettype none

module flash_access_dev (
   // Clock and reset
   input  wire logic  clk_sys,
   input  wire logic  reset,
   // Link to the host end
   flash_bus_if.dev   bus,
   // Status seen by the user side
   output logic       sealedFlag,
   output logic       fullAccessFlag,
   output logic       commitDone
);

   function automatic logic [4:0] blockOf(input logic [7:0] sc, input logic [7:0] blk);
      logic [4:0] r;
      r = 5'h00;
      case (sc)
         `SC_SAFETY:    r = {blk == 8'h00, 4'd0};
         `SC_INHIBIT:   r = {blk == 8'h00, 4'd1};
         `SC_CHARGE:    r = {blk == 8'h00, 4'd2};
         `SC_TERM:      r = {blk == 8'h00, 4'd3};
         `SC_DATA:      r = {blk == 8'h00, 4'd4};
         `SC_DISCHARGE: r = {blk == 8'h00, 4'd5};
         `SC_REGS:      r = {blk == 8'h00, 4'd6};
         `SC_POWER:     r = {blk == 8'h00, 4'd7};
         // info area through the general path
         `SC_INFO:      r = {blk == 8'h00, `BLK_INFO};
         `SC_GAS:       r = {blk < `GAS_BLOCKS, 4'(`BLK_GAS + blk[3:0])};
         `SC_SECURITY:  r = {blk == 8'h00, `BLK_SEC};
         default:       r = 5'h00;
      endcase
      return r;
   endfunction : blockOf

   function automatic logic [7:0] nvDefault(input logic [8:0] idx);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         `IDX_OT_CHG:           v = 8'(`DEF_OT_CHG >> 8);
         `IDX_OT_CHG + 9'd1:    v = 8'(`DEF_OT_CHG);
         `IDX_CHG_VOLT:         v = 8'(`DEF_CHG_VOLT >> 8);
         `IDX_CHG_VOLT + 9'd1:  v = 8'(`DEF_CHG_VOLT);
         `IDX_DES_CAP:          v = 8'(`DEF_DES_CAP >> 8);
         `IDX_DES_CAP + 9'd1:   v = 8'(`DEF_DES_CAP);
         `IDX_TERM_VOLT:        v = 8'(`DEF_TERM_VOLT >> 8);
         `IDX_TERM_VOLT + 9'd1: v = 8'(`DEF_TERM_VOLT);
         `KEY_UN0:              v = 8'(`KEY_UN0_DEF >> 8);
         `KEY_UN0 + 9'd1:       v = 8'(`KEY_UN0_DEF);
         `KEY_UN1:              v = 8'(`KEY_UN1_DEF >> 8);
         `KEY_UN1 + 9'd1:       v = 8'(`KEY_UN1_DEF);
         `KEY_FU0:              v = 8'(`KEY_FU0_DEF >> 8);
         `KEY_FU0 + 9'd1:       v = 8'(`KEY_FU0_DEF);
         `KEY_FU1:              v = 8'(`KEY_FU1_DEF >> 8);
         `KEY_FU1 + 9'd1:       v = 8'(`KEY_FU1_DEF);
         default:               v = 8'h00;
      endcase
      return v;
   endfunction : nvDefault

   logic [7:0]                nv_r [`NV_BYTES];
   logic [7:0]                win_r [`WIN_BYTES];
   logic [7:0]                subclass_r;
   logic [7:0]                block_r;
   logic [7:0]                mode_r;
   logic [7:0]                ctrlLo_r;
   logic [5:0]                wrCount_r;
   logic [3:0]                base_r;
   logic                      targetOk_r;
   logic                      keyPend_r;
   flash_access_pkg::sec_t    sec_r;
   flash_access_pkg::sec_t    secNxt;
   logic                      rspValid_r;
   logic [7:0]                rspData_r;
   logic                      sealed_r;
   logic                      fullN_r;
   logic                      commit_r;
   logic [7:0]                winSum;

   wire        wr          = bus.cmdValid & bus.cmdWrite;
   wire [7:0]  addr        = bus.cmdAddr;
   wire [7:0]  din         = bus.cmdData;
   wire        isSealed    = (sec_r == flash_access_pkg::SEALED);
   wire        isWin       = (addr[7:5] == 3'b010);
   // sealed mode locks subclass, mode and window writes
   wire        wrSub       = wr & (addr == `ADDR_SUBCLASS) & ~isSealed;
   wire        wrMode      = wr & (addr == `ADDR_MODE) & ~isSealed;
   wire        wrWin       = wr & isWin & ~isSealed;
   wire        wrBlk       = wr & (addr == `ADDR_BLOCK);
   wire        wrSum       = wr & (addr == `ADDR_CSUM);
   wire        ctlDone     = wr & (addr == `ADDR_CTRL_HI);
   wire [15:0] ctrlWord    = {din, ctrlLo_r};
   // restricted path when sealed or mode nonzero
   wire        restricted  = isSealed | (mode_r != `MODE_GENERAL);
   // info selection by block value only
   wire        infoSel     = (din == `INFO_SEL_A) | (din == `INFO_SEL_B);
   wire [4:0]  genTarget   = blockOf(subclass_r, din);
   wire        tgtOk       = restricted ? infoSel : genTarget[4];
   wire [3:0]  tgtBlk      = restricted ? `BLK_INFO : genTarget[3:0];
   wire        loadWin     = wrBlk & tgtOk;
   // more than a block of window writes
   wire        overflow    = (wrCount_r > 6'd32);
   wire        sumOk       = (~winSum == din);
   // key block writable only in full access
   wire        keyBlkOk    = (base_r != `BLK_SEC) | (sec_r == flash_access_pkg::FULL);
   wire        commit      = wrSum & sumOk & targetOk_r & ~overflow & ~isSealed & keyBlkOk;
   wire [15:0] unK0        = {nv_r[`KEY_UN0 + 9'd1], nv_r[`KEY_UN0]};
   wire [15:0] unK1        = {nv_r[`KEY_UN1 + 9'd1], nv_r[`KEY_UN1]};
   wire [15:0] fuK0        = {nv_r[`KEY_FU0 + 9'd1], nv_r[`KEY_FU0]};
   wire [15:0] fuK1        = {nv_r[`KEY_FU1 + 9'd1], nv_r[`KEY_FU1]};
   wire [15:0] wantK1      = isSealed ? unK1 : fuK1;
   wire [15:0] wantK0      = isSealed ? unK0 : fuK0;
   wire        canRise     = (sec_r != flash_access_pkg::FULL);
   wire        pairDone    = ctlDone & keyPend_r & canRise & (ctrlWord == wantK0);
   wire        sealCmd     = ctlDone & ~isSealed & (ctrlWord == `SUBCMD_SEAL);
   wire [15:0] ctrlStatus  = 16'(({15'h0000, isSealed} << `CS_SS_BIT)
                           | ({15'h0000, sec_r != flash_access_pkg::FULL} << `CS_FAS_BIT));

   always_comb begin
      winSum = 8'h00;
      for (int i = 0; i < `WIN_BYTES; i++) begin
         winSum = 8'(winSum + win_r[i]);
      end
   end

   wire [7:0] rdData =
        (addr == `ADDR_CTRL_LO)  ? ctrlStatus[7:0]  :
        (addr == `ADDR_CTRL_HI)  ? ctrlStatus[15:8] :
        (addr == `ADDR_SUBCLASS) ? subclass_r       :
        (addr == `ADDR_BLOCK)    ? block_r          :
        isWin                    ? win_r[addr[4:0]] :
        (addr == `ADDR_CSUM)     ? ~winSum          :
        (addr == `ADDR_MODE)     ? mode_r           : 8'h00;

   always_comb begin
      secNxt = sec_r;
      if (pairDone) begin
         secNxt = isSealed ? flash_access_pkg::UNSEALED : flash_access_pkg::FULL;
      end else if (sealCmd) begin
         secNxt = flash_access_pkg::SEALED;
      end
   end

   // any control word re-arms or breaks
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         keyPend_r <= 1'b0;
      end else if (ctlDone) begin
         keyPend_r <= ~pairDone & ~sealCmd & canRise & (ctrlWord == wantK1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sec_r      <= flash_access_pkg::SEALED;
         sealed_r   <= 1'b1;
         fullN_r    <= 1'b1;
         ctrlLo_r   <= 8'h00;
         subclass_r <= 8'h00;
         block_r    <= 8'h00;
         mode_r     <= `MODE_GENERAL;
      end else begin
         sec_r    <= secNxt;
         sealed_r <= (secNxt == flash_access_pkg::SEALED);
         fullN_r  <= (secNxt != flash_access_pkg::FULL);
         if (wr && addr == `ADDR_CTRL_LO) begin
            ctrlLo_r <= din;
         end
         // subclass kept for the next block selection
         if (wrSub) begin
            subclass_r <= din;
         end
         if (wrBlk) begin
            block_r <= din;
         end
         if (wrMode) begin
            mode_r <= din;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         targetOk_r <= 1'b0;
         base_r     <= 4'd0;
         wrCount_r  <= 6'd0;
         for (int i = 0; i < `WIN_BYTES; i++) begin
            win_r[i] <= 8'h00;
         end
      end else if (wrBlk) begin
         targetOk_r <= tgtOk;
         base_r     <= tgtBlk;
         wrCount_r  <= 6'd0;
         for (int i = 0; i < `WIN_BYTES; i++) begin
            if (loadWin) begin
               win_r[i] <= nv_r[{tgtBlk, 5'(i)}];
            end
         end
      end else if (commit) begin
         wrCount_r <= 6'd0;
      end else if (wrWin) begin
         win_r[addr[4:0]] <= din;
         if (wrCount_r != `WIN_OVER) begin
            wrCount_r <= wrCount_r + 6'd1;
         end
      end
   end

   // Reset stands in for the power-up image; a real store would not reload here.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         for (int i = 0; i < `NV_BYTES; i++) begin
            nv_r[i] <= nvDefault(9'(i));
         end
      end else if (commit) begin
         // whole block at once, never partial
         for (int j = 0; j < `WIN_BYTES; j++) begin
            nv_r[{base_r, 5'(j)}] <= win_r[j];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rspValid_r <= 1'b0;
         rspData_r  <= 8'h00;
         commit_r   <= 1'b0;
      end else begin
         rspValid_r <= bus.cmdValid;
         rspData_r  <= bus.cmdWrite ? 8'h00 : rdData;
         commit_r   <= commit;
      end
   end

   assign bus.rspValid   = rspValid_r;
   assign bus.rspData    = rspData_r;
   assign sealedFlag     = sealed_r;
   assign fullAccessFlag = fullN_r;
   assign commitDone     = commit_r;

endmodule : flash_access_dev

`default_nettype wire

// ===== core/flash_access_host.sv
// Host end: Wishbone classic slave that turns register writes into link commands.
// Assumes software orders subclass, block, window and checksum writes itself.
`include "flash_access_cfg.svh"
`default_nettype none

module flash_access_host (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // Wishbone classic slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   // Link to the gauge end
   flash_bus_if.host        bus
);

   flash_access_pkg::host_state_t st_r;
   logic        ack_r;
   logic [31:0] dat_r;
   logic [31:0] key_r;
   logic        keyMode_r;
   logic [1:0]  opIdx_r;
   logic        oneWrite_r;
   logic [7:0]  oneAddr_r;
   logic [7:0]  oneData_r;
   logic        cmdValid_r;
   logic        cmdWrite_r;
   logic [7:0]  cmdAddr_r;
   logic [7:0]  cmdData_r;
   logic [7:0]  lastRd_r;
   logic [7:0]  sum_r;

   wire        req    = cyc_i & stb_i & ~ack_r;
   wire        idle   = (st_r == flash_access_pkg::H_IDLE);
   wire        wrReq  = req & we_i & (|sel_i);
   wire        goCmd  = wrReq & idle & (adr_i == `HREG_CMD);
   wire        goKey  = wrReq & idle & (adr_i == `HREG_KEY);
   wire        clrSum = wrReq & (adr_i == `HREG_CSUM);
   // key 1 then key 0, low control byte carries stored high byte
   wire [15:0] keyNow = opIdx_r[1] ? key_r[15:0] : key_r[31:16];
   wire [7:0]  opAddr = keyMode_r ? {7'h00, opIdx_r[0]} : oneAddr_r;
   wire [7:0]  opData = keyMode_r ? (opIdx_r[0] ? keyNow[7:0] : keyNow[15:8]) : oneData_r;
   wire        opWr   = keyMode_r | oneWrite_r;
   wire        lastOp = ~keyMode_r | (opIdx_r == 2'd3);
   wire        winOp  = (cmdAddr_r[7:5] == 3'b010) & cmdWrite_r;
   wire [31:0] rdMux  =
        (adr_i == `HREG_KEY)  ? key_r :
        (adr_i == `HREG_STAT) ? {16'h0000, lastRd_r, 7'h00, ~idle} :
        (adr_i == `HREG_CSUM) ? {24'h000000, ~sum_r} : 32'h00000000;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ack_r <= 1'b0;
         dat_r <= 32'h00000000;
      end else begin
         ack_r <= req;
         dat_r <= (req & ~we_i) ? rdMux : 32'h00000000;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_r       <= flash_access_pkg::H_IDLE;
         key_r      <= 32'h00000000;
         keyMode_r  <= 1'b0;
         opIdx_r    <= 2'd0;
         oneWrite_r <= 1'b0;
         oneAddr_r  <= 8'h00;
         oneData_r  <= 8'h00;
         cmdValid_r <= 1'b0;
         cmdWrite_r <= 1'b0;
         cmdAddr_r  <= 8'h00;
         cmdData_r  <= 8'h00;
         lastRd_r   <= 8'h00;
      end else begin
         cmdValid_r <= 1'b0;
         unique case (st_r)
            flash_access_pkg::H_IDLE: begin
               if (goCmd) begin
                  oneData_r  <= dat_i[7:0];
                  oneAddr_r  <= dat_i[15:8];
                  oneWrite_r <= dat_i[`CMD_WRITE_BIT];
                  keyMode_r  <= 1'b0;
                  opIdx_r    <= 2'd0;
                  st_r       <= flash_access_pkg::H_SEND;
               end else if (goKey) begin
                  key_r     <= dat_i;
                  keyMode_r <= 1'b1;
                  opIdx_r   <= 2'd0;
                  st_r      <= flash_access_pkg::H_SEND;
               end
            end
            flash_access_pkg::H_SEND: begin
               cmdValid_r <= 1'b1;
               cmdWrite_r <= opWr;
               cmdAddr_r  <= opAddr;
               cmdData_r  <= opData;
               st_r       <= flash_access_pkg::H_WAIT;
            end
            flash_access_pkg::H_WAIT: begin
               if (bus.rspValid) begin
                  if (!cmdWrite_r) begin
                     lastRd_r <= bus.rspData;
                  end
                  opIdx_r <= opIdx_r + 2'd1;
                  st_r    <= lastOp ? flash_access_pkg::H_IDLE : flash_access_pkg::H_SEND;
               end
            end
            default: st_r <= flash_access_pkg::H_IDLE;
         endcase
      end
   end

   // running byte sum of window writes; a clear in the same cycle as a window write restarts the sum from that byte.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sum_r <= 8'h00;
      end else if (cmdValid_r && winOp) begin
         sum_r <= clrSum ? cmdData_r : 8'(sum_r + cmdData_r);
      end else if (clrSum) begin
         sum_r <= 8'h00;
      end
   end

   assign ack_o        = ack_r;
   assign dat_o        = dat_r;
   assign bus.cmdValid = cmdValid_r;
   assign bus.cmdWrite = cmdWrite_r;
   assign bus.cmdAddr  = cmdAddr_r;
   assign bus.cmdData  = cmdData_r;

endmodule : flash_access_host

`default_nettype wire

// ===== inc/flash_access_cfg.svh
// Constants shared by both ends of the parameter-store access link.
// Assumes it is included by bare name from files that see the inc/ folder.
`ifndef FLASH_ACCESS_CFG_SVH
`define FLASH_ACCESS_CFG_SVH

// Command space seen over the link.
`define ADDR_CTRL_LO   8'h00
`define ADDR_CTRL_HI   8'h01
`define ADDR_SUBCLASS  8'h3e
`define ADDR_BLOCK     8'h3f
`define ADDR_WIN_BASE  8'h40
`define ADDR_CSUM      8'h60
`define ADDR_MODE      8'h61
`define WIN_BYTES      32
`define WIN_OVER       6'd33

// Access mode selector values and restricted block selector values.
`define MODE_GENERAL   8'h00
`define MODE_INFO      8'h01
`define INFO_SEL_A     8'h01
`define INFO_SEL_B     8'h02

// Subclass numbers of the parameter store.
`define SC_SAFETY      8'h02
`define SC_INHIBIT     8'h20
`define SC_CHARGE      8'h22
`define SC_TERM        8'h24
`define SC_DATA        8'h30
`define SC_DISCHARGE   8'h31
`define SC_INFO        8'h39
`define SC_REGS        8'h40
`define SC_POWER       8'h44
`define SC_GAS         8'h50
`define SC_SECURITY    8'h70
`define GAS_BLOCKS     8'h03

// Storage layout: thirteen 32-byte blocks.
`define NV_BYTES       416
`define BLK_GAS        4'd9
`define BLK_INFO       4'd8
`define BLK_SEC        4'd12
`define KEY_UN0        9'd384
`define KEY_UN1        9'd386
`define KEY_FU0        9'd388
`define KEY_FU1        9'd390

// Key defaults (arbitrary) and a few parameter defaults, big-endian.
`define KEY_UN0_DEF    16'h5a01
`define KEY_UN1_DEF    16'ha502
`define KEY_FU0_DEF    16'h3c03
`define KEY_FU1_DEF    16'hc304
`define DEF_OT_CHG     16'h0226
`define DEF_CHG_VOLT   16'h1068
`define DEF_DES_CAP    16'h0474
`define DEF_TERM_VOLT  16'h0c80
`define IDX_OT_CHG     9'd0
`define IDX_CHG_VOLT   9'd64
`define IDX_DES_CAP    9'd134
`define IDX_TERM_VOLT  9'd332

// Control word: seal subcommand and status bit positions.
`define SUBCMD_SEAL    16'h0020
`define CS_SS_BIT      13
`define CS_FAS_BIT     14

// Host end register map (byte addresses on the Wishbone side).
`define HREG_CMD       4'h0
`define HREG_KEY       4'h4
`define HREG_STAT      4'h8
`define HREG_CSUM      4'hc
`define CMD_WRITE_BIT  16

`endif

// ===== inc/flash_access_pkg.sv
// Types shared by both ends of the parameter-store access link.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package flash_access_pkg;
   typedef enum logic [1:0] {SEALED, UNSEALED, FULL} sec_t;
   typedef enum logic [1:0] {H_IDLE, H_SEND, H_WAIT} host_state_t;
endpackage : flash_access_pkg

`default_nettype wire

// ===== inc/flash_bus_if.sv
// Byte command link between the host end and the gauge end.
// Assumes both ends share clk_sys; the bench supplies nothing else.
`default_nettype none

interface flash_bus_if;
   logic       cmdValid;
   logic       cmdWrite;
   logic [7:0] cmdAddr;
   logic [7:0] cmdData;
   logic       rspValid;
   logic [7:0] rspData;

   modport dev  (input cmdValid, cmdWrite, cmdAddr, cmdData, output rspValid, rspData);
   modport host (output cmdValid, cmdWrite, cmdAddr, cmdData, input rspValid, rspData);
endinterface : flash_bus_if

`default_nettype wire

// ===== test/flash_block_access_security_props.sv
// Checker for the byte link between the host end and the gauge end.
// Assumes the bench instantiates it beside the interface, all on clk_sys.
`default_nettype none

module flash_block_access_security_props (
   // Clock and reset
   input wire logic       clk_sys,
   input wire logic       reset,
   // Link signals
   input wire logic       cmdValid,
   input wire logic       cmdWrite,
   input wire logic [7:0] cmdAddr,
   input wire logic [7:0] cmdData,
   input wire logic       rspValid,
   input wire logic [7:0] rspData,
   // Gauge status
   input wire logic       sealedFlag,
   input wire logic       fullAccessFlag,
   input wire logic       commitDone
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   wire  ctrlHiWr = cmdValid && cmdWrite && (cmdAddr == 8'h01);
   wire  csumWr   = cmdValid && cmdWrite && (cmdAddr == 8'h60);
   logic ctrlHiD1_r;
   logic ctrlHiD2_r;

   // Flags load from the next state on the same edge as the state, so a change comes one cycle after its command.
   always_ff @(posedge clk_sys) begin
      ctrlHiD1_r <= reset ? 1'b0 : ctrlHiWr;
      ctrlHiD2_r <= reset ? 1'b0 : ctrlHiD1_r;
   end

   property p_rsp_next;
      cmdValid |=> rspValid && (!$past(cmdWrite) || rspData == 8'h00);
   endproperty
   a_rsp_next: assert property (p_rsp_next) else $error("link answer missing or late");
   property p_rsp_cause;
      rspValid |-> $past(cmdValid);
   endproperty
   a_rsp_cause: assert property (p_rsp_cause) else $error("answer without command");
   property p_cmd_space;
      cmdValid |=> !cmdValid [*2];
   endproperty
   a_cmd_space: assert property (p_cmd_space) else $error("commands too close");
   property p_seal_fall;
      $fell(sealedFlag) |-> ctrlHiD1_r || ctrlHiD2_r;
   endproperty
   a_seal_fall: assert property (p_seal_fall) else $error("unsealed without key word");
   property p_full_fall;
      $fell(fullAccessFlag) |-> (ctrlHiD1_r || ctrlHiD2_r) && !sealedFlag;
   endproperty
   a_full_fall: assert property (p_full_fall) else $error("full access without key");
   property p_seal_rise;
      $rose(sealedFlag) |-> ctrlHiD1_r || ctrlHiD2_r || $past(reset);
   endproperty
   a_seal_rise: assert property (p_seal_rise) else $error("sealed without command");
   property p_sec_order;
      !fullAccessFlag |-> !sealedFlag;
   endproperty
   a_sec_order: assert property (p_sec_order) else $error("sealed and full at once");
   property p_commit_csum;
      commitDone |-> rspValid && $past(csumWr);
   endproperty
   a_commit_csum: assert property (p_commit_csum) else $error("commit without checksum");
   property p_commit_sealed;
      commitDone |-> !$past(sealedFlag);
   endproperty
   a_commit_sealed: assert property (p_commit_sealed) else $error("commit while sealed");

   c_commit: cover property (commitDone);
   c_unseal: cover property ($fell(sealedFlag));
   c_full:   cover property ($fell(fullAccessFlag));
   c_reseal: cover property ($rose(sealedFlag) && !$past(reset));
endmodule : flash_block_access_security_props

`default_nettype wire

// ===== test/tb_flash_block_access_security.sv
// Bench: Wishbone master on the host end, gauge end behind the link, byte model.
// Assumes the design files and the inc/ folder are on the compile path.
`include "flash_access_cfg.svh"
`default_nettype none

module tb_flash_block_access_security;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, reset, wbCyc, wbStb, wbWe, wbAck;
   logic        sealedFlag, fullAccessFlag, commitDone;
   logic [3:0]  wbAdr, wbSel;
   logic [31:0] wbDatW, wbDatR, q;
   logic [7:0]  mdlWin [32];
   logic [7:0]  mdlInfo [32];
   logic [7:0]  rd;
   int          mismatches, samples_checked, commits, base, sec;

   flash_bus_if link ();
   flash_access_host i_flash_access_host (.clk_sys(clk_sys), .reset(reset), .cyc_i(wbCyc),
      .stb_i(wbStb), .we_i(wbWe), .adr_i(wbAdr), .sel_i(wbSel), .dat_i(wbDatW),
      .dat_o(wbDatR), .ack_o(wbAck), .bus(link.host));
   flash_access_dev i_flash_access_dev (.clk_sys(clk_sys), .reset(reset), .bus(link.dev),
      .sealedFlag(sealedFlag), .fullAccessFlag(fullAccessFlag), .commitDone(commitDone));
   flash_block_access_security_props i_flash_block_access_security_props (.clk_sys(clk_sys),
      .reset(reset), .cmdValid(link.cmdValid), .cmdWrite(link.cmdWrite),
      .cmdAddr(link.cmdAddr), .cmdData(link.cmdData), .rspValid(link.rspValid),
      .rspData(link.rspData), .sealedFlag(sealedFlag), .fullAccessFlag(fullAccessFlag),
      .commitDone(commitDone));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (commitDone === 1'b1) begin
         commits++;
      end
   end

   task automatic test_done();
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bound(input int n);
      if (n >= 30) begin
         mismatches++;
         test_done();
      end
   endtask : bound
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      int n;
      n = 0;
      @(posedge clk_sys);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= adr;
      wbDatW <= dat;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wbAck !== 1'b1 && n < 30);
      bound(n);
      q = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : wb
   // Software must see busy low before it hands over the next command.
   task automatic poll();
      int n;
      n = 0;
      do begin
         wb(1'b0, `HREG_STAT, 32'h0);
         n++;
      end while (q[0] !== 1'b0 && n < 30);
      bound(n);
      rd = q[15:8];
   endtask : poll
   task automatic cmd(input logic we, input logic [7:0] adr, input logic [7:0] dat);
      wb(1'b1, `HREG_CMD, {15'h0, we, adr, dat});
      poll();
   endtask : cmd
   task automatic key(input logic [7:0] lo, input logic [7:0] hi);
      cmd(1'b1, `ADDR_CTRL_LO, lo);
      cmd(1'b1, `ADDR_CTRL_HI, hi);
   endtask : key
   task automatic status();
      chk({sealedFlag, fullAccessFlag}, {sec == 0, sec != 2});
      cmd(1'b0, `ADDR_CTRL_HI, 8'h00);
      chk(rd[6:5], {sec != 2, sec == 0});
   endtask : status
   task automatic fill_win(input int n);
      for (int i = 0; i < n; i++) begin
         mdlWin[i % 32] = 8'($urandom());
         cmd(1'b1, `ADDR_WIN_BASE + 8'(i % 32), mdlWin[i % 32]);
      end
   endtask : fill_win
   task automatic check_win();
      for (int i = 0; i < 32; i++) begin
         cmd(1'b0, `ADDR_WIN_BASE + 8'(i), 8'h00);
         chk(rd, mdlWin[i]);
      end
   endtask : check_win
   function automatic logic [7:0] csum();
      logic [7:0] s;
      s = 8'h00;
      for (int i = 0; i < 32; i++) begin
         s = s + mdlWin[i];
      end
      return ~s;
   endfunction : csum
   task automatic commit(input logic [7:0] v, input int exp);
      base = commits;
      cmd(1'b1, `ADDR_CSUM, v);
      chk(commits - base, exp);
   endtask : commit

   initial begin
      {reset, wbCyc, wbStb, wbWe, wbAdr, wbDatW, wbSel} = {4'h8, 4'h0, 32'h0, 4'hf};
      {mismatches, samples_checked, commits, sec} = '0;
      base = int'($urandom(11962));
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      status();
      $display("test reset state done");
      cmd(1'b1, `ADDR_BLOCK, `INFO_SEL_A);
      cmd(1'b1, `ADDR_WIN_BASE, 8'h5a);
      cmd(1'b0, `ADDR_WIN_BASE, 8'h00);
      chk(rd, 8'h00);
      commit(8'hff, 0);
      $display("test sealed window done");
      key(8'ha5, 8'h02);
      key(8'h5a, 8'h02);
      status();
      key(8'h5a, 8'h01);
      key(8'ha5, 8'h02);
      key(8'h34, 8'h12);
      key(8'h5a, 8'h01);
      status();
      key(8'h02, 8'ha5);
      key(8'h01, 8'h5a);
      status();
      key(8'ha5, 8'h02);
      key(8'h5a, 8'h01);
      sec = 1;
      status();
      $display("test unseal keys done");
      cmd(1'b1, `ADDR_MODE, `MODE_GENERAL);
      cmd(1'b1, `ADDR_SUBCLASS, `SC_DATA);
      cmd(1'b1, `ADDR_BLOCK, 8'h00);
      cmd(1'b0, `ADDR_WIN_BASE + 8'd6, 8'h00);
      chk(rd, 8'h04);
      cmd(1'b1, `ADDR_SUBCLASS, `SC_GAS);
      cmd(1'b1, `ADDR_BLOCK, 8'h01);
      cmd(1'b0, `ADDR_WIN_BASE + 8'd12, 8'h00);
      chk(rd, 8'h0c);
      wb(1'b1, `HREG_CSUM, 32'h0);
      fill_win(32);
      cmd(1'b0, `ADDR_CSUM, 8'h00);
      chk(rd, csum());
      wb(1'b0, `HREG_CSUM, 32'h0);
      chk(q[7:0], csum());
      commit(csum() ^ 8'h01, 0);
      commit(csum(), 1);
      cmd(1'b1, `ADDR_BLOCK, 8'h01);
      check_win();
      fill_win(33);
      commit(csum(), 0);
      $display("test general commit done");
      cmd(1'b1, `ADDR_SUBCLASS, `SC_INFO);
      cmd(1'b1, `ADDR_BLOCK, 8'h00);
      fill_win(32);
      commit(csum(), 1);
      cmd(1'b1, `ADDR_MODE, `MODE_INFO);
      cmd(1'b1, `ADDR_BLOCK, `INFO_SEL_B);
      check_win();
      fill_win(32);
      commit(csum(), 1);
      mdlInfo = mdlWin;
      cmd(1'b1, `ADDR_BLOCK, `INFO_SEL_A);
      check_win();
      $display("test info area done");
      // key block locked below full access
      cmd(1'b1, `ADDR_MODE, `MODE_GENERAL);
      cmd(1'b1, `ADDR_SUBCLASS, `SC_SECURITY);
      cmd(1'b1, `ADDR_BLOCK, 8'h00);
      fill_win(32);
      commit(csum(), 0);
      wb(1'b1, `HREG_KEY, {`KEY_FU1_DEF, `KEY_FU0_DEF});
      poll();
      sec = 2;
      status();
      cmd(1'b1, `ADDR_BLOCK, 8'h00);
      fill_win(32);
      commit(csum(), 1);
      key(8'(`SUBCMD_SEAL), 8'h00);
      sec = 0;
      status();
      mdlWin = mdlInfo;
      cmd(1'b1, `ADDR_BLOCK, `INFO_SEL_A);
      check_win();
      $display("test full access and seal done");
      test_done();
   end
endmodule : tb_flash_block_access_security

`default_nettype wire
